// [rtl/pdd_fmt.sv]
// Value-to-glyph formatter for the five-digit display
`timescale 1ns/10ps
module pdd_fmt (
  input  pdd_pkg::pdd_fmt_req_t req,
  output pdd_pkg::pdd_disp_t    disp
);
  import pdd_pkg::*;

  // Shift-add-three binary to ten BCD digits
  function automatic logic [39:0] to_bcd(input logic [31:0] bin);
    logic [39:0] b;
    b = '0;
    for (int i = 31; i >= 0; i--) begin
      for (int j = 0; j < 10; j++) begin
        if (b[j*4 +: 4] >= 4'h5) begin
          b[j*4 +: 4] = b[j*4 +: 4] + 4'h3;
        end
      end
      b = {b[38:0], bin[i]};
    end
    return b;
  endfunction

  logic [31:0] sext;
  logic        neg;
  logic [31:0] mag;
  logic [39:0] bcd;

  assign sext = req.is32 ? req.value
                         : {{16{req.value[15]}}, req.value[15:0]};
  assign neg  = sext[31];
  assign mag  = neg ? 32'(-sext) : sext;
  assign bcd  = to_bcd(mag);

  always_comb begin
    disp.seg = {5{GL_BLANK}};
    disp.dp  = '0;
    if (req.hex) begin
      // No sign shown in hex
      if (!req.is32) begin
        for (int k = 0; k < 4; k++) begin
          disp.seg[k] = pdd_glyph(req.value[k*4 +: 4]);
        end
      end else begin
        disp.seg[4] = req.high ? GL_HIGH : GL_LOW;
        for (int k = 0; k < 4; k++) begin
          disp.seg[k] = pdd_glyph(req.high ? req.value[16 + k*4 +: 4]
                                           : req.value[k*4 +: 4]);
        end
      end
    end else begin
      for (int k = 0; k < 5; k++) begin
        // Leading zeros kept, all five positions lit
        disp.seg[k] = pdd_glyph((req.is32 && req.high)
                                ? bcd[20 + k*4 +: 4]
                                : bcd[k*4 +: 4]);
      end
      if (req.is32 && req.high) begin
        disp.dp[0] = 1'b1;
      end
      if (neg) begin
        disp.dp[4] = 1'b1;
        disp.dp[3] = 1'b1;
      end
    end
  end

endmodule

// [rtl/pdd_panel.sv]
// Front-panel display, keypad, jog and output-forcing logic
// Summary of operation
// - 16-bit decimal fills all five digits with leading zeros.
// - 16-bit hex shows four digits, leftmost position blank.
// - 32-bit decimal splits into low five digits and dotted high page.
// - 32-bit hex pages carry h or L glyph before four digits.
// - Negative decimal lights two leftmost points; hex has no sign.
// - Same formatter serves monitor and parameter editing.
// - Monitor 32-bit toggles page and radix; parameters fixed format.
// - Set on a fault-record parameter shows that stored record.
// - Set on jog-speed parameter shows jog speed, default 20.
// - Up/down adjust jog speed; next set enters jog mode.
// - Jog: up held runs forward, down held reverse, release stops.
// - Jog motion only while servo is enabled.
// - Writing 406 to special function forces outputs, shows them.
// - Forced mask bit n drives output n+1.
// - Forcing ends on reset or special function written 400.
// - Forced mask displayed in hex, leftmost digit blank.
// - Input view shows inputs 1..9 as hex bitmap.
// - Output view shows outputs 1..6 as hex bitmap.
// - Shift held two seconds flips sign if result stays in range.
`timescale 1ns/10ps
module pdd_panel #(
  parameter int unsigned      HOLD_CYC = pdd_pkg::SIGN_HOLD_CYC,
  parameter logic [15:0]      JOG_MIN  = pdd_pkg::JOG_MIN_DEF,
  parameter logic [15:0]      JOG_MAX  = pdd_pkg::JOG_MAX_DEF
) (
  input  wire logic                SYS_CLK,
  input  wire logic                RST_N,
  input  wire logic                CLK_EN,
  input  wire logic [3:0]          REG_ADDR,
  input  wire logic [15:0]         REG_WDATA,
  input  wire logic                REG_WR,
  input  wire logic                REG_RD,
  output logic [15:0]              REG_RDATA,
  input  wire logic                KEY_UP,
  input  wire logic                KEY_DOWN,
  input  wire logic                KEY_SET,
  input  wire logic                KEY_SHIFT,
  input  wire logic                KEY_MODE,
  input  wire logic                SERVO_ON,
  input  wire logic [31:0]         MON_VALUE,
  input  wire logic                MON_IS32,
  input  wire logic [4:0][15:0]    FAULT_REC,
  input  wire logic [8:0]          DI_STATE,
  input  wire logic [5:0]          DO_NORMAL,
  output pdd_pkg::pdd_disp_t       DISP,
  output logic [5:0]               DO_OUT,
  output logic                     JOG_FWD,
  output logic                     JOG_REV,
  output logic [15:0]              JOG_SPEED
);
  import pdd_pkg::*;

  logic [1:0]   view_q;
  logic [3:0]   psel_q;
  logic [15:0]  spec_q;
  logic [5:0]   mask_q;
  logic [15:0]  jog_q;
  logic         forced_q;
  logic         mon_hex_q;
  logic         mon_high_q;
  pdd_state_t   state_q;
  pdd_state_t   state_d;
  logic [31:0]  hold_cnt_q;
  logic         hold_done_q;
  logic         up_q;
  logic         down_q;
  logic         set_q;
  logic         shift_q;
  logic         mode_q;
  logic         up_edge;
  logic         down_edge;
  logic         set_edge;
  logic         shift_edge;
  logic         mode_edge;
  logic         wr_view;
  logic         wr_psel;
  logic         wr_spec;
  logic         wr_mask;
  logic         wr_jog;
  logic         is_fault;
  logic         jog_edit;
  logic         sign_fire;
  logic [15:0]  jog_neg;
  logic         neg_ok;
  logic [15:0]  status;
  logic [15:0]  rd_mux;
  pdd_fmt_req_t req;
  pdd_disp_t    fmt_out;

  // Register port decode
  assign wr_view = REG_WR && (REG_ADDR == ADDR_VIEW);
  assign wr_psel = REG_WR && (REG_ADDR == ADDR_PARAM_SEL);
  assign wr_spec = REG_WR && (REG_ADDR == ADDR_SPEC_FUNC);
  assign wr_mask = REG_WR && (REG_ADDR == ADDR_FORCE_MSK);
  assign wr_jog  = REG_WR && (REG_ADDR == ADDR_JOG_SPEED);

  // Key press edges; keys arrive synchronous to the clock
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      up_q    <= 1'b0;
      down_q  <= 1'b0;
      set_q   <= 1'b0;
      shift_q <= 1'b0;
      mode_q  <= 1'b0;
    end else if (CLK_EN) begin
      up_q    <= KEY_UP;
      down_q  <= KEY_DOWN;
      set_q   <= KEY_SET;
      shift_q <= KEY_SHIFT;
      mode_q  <= KEY_MODE;
    end
  end

  assign up_edge    = KEY_UP && !up_q;
  assign down_edge  = KEY_DOWN && !down_q;
  assign set_edge   = KEY_SET && !set_q;
  assign shift_edge = KEY_SHIFT && !shift_q;
  assign mode_edge  = KEY_MODE && !mode_q;

  assign is_fault = (psel_q <= PSEL_FAULT_LAST);
  assign jog_edit = (view_q == VIEW_PARAM) && (state_q == ST_SHOW)
                    && (psel_q == PSEL_JOG);

  // Panel sequencing in parameter view
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_SEL: begin
        if (set_edge && (is_fault || psel_q == PSEL_JOG)) begin
          state_d = ST_SHOW;
        end
      end
      ST_SHOW: begin
        if (mode_edge) begin
          state_d = ST_SEL;
        end else if (set_edge && psel_q == PSEL_JOG) begin
          state_d = ST_JOG;
        end else if (set_edge) begin
          state_d = ST_SEL;
        end
      end
      ST_JOG: begin
        if (mode_edge) begin
          state_d = ST_SEL;
        end
      end
      default: state_d = ST_SEL;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= ST_SEL;
    end else if (CLK_EN) begin
      // Leaving parameter view or reselecting drops any open operation
      if (view_q != VIEW_PARAM || wr_view || wr_psel) begin
        state_q <= ST_SEL;
      end else begin
        state_q <= state_d;
      end
    end
  end

  // View and parameter selection; bus write wins over keys
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      view_q <= VIEW_MON;
    end else if (CLK_EN) begin
      if (wr_view) begin
        view_q <= REG_WDATA[1:0];
      end else if (wr_spec && REG_WDATA == SF_FORCE_ON) begin
        view_q <= VIEW_DO;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      psel_q <= '0;
    end else if (CLK_EN) begin
      if (wr_psel) begin
        psel_q <= REG_WDATA[3:0];
      end else if (view_q == VIEW_PARAM && state_q == ST_SEL) begin
        if (up_edge) begin
          psel_q <= psel_q + 4'h1;
        end else if (down_edge) begin
          psel_q <= psel_q - 4'h1;
        end
      end
    end
  end

  // Special function and output forcing
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      spec_q   <= '0;
      forced_q <= 1'b0;
    end else if (CLK_EN && wr_spec) begin
      spec_q <= REG_WDATA;
      if (REG_WDATA == SF_FORCE_ON) begin
        forced_q <= 1'b1;
      end else if (REG_WDATA == SF_FORCE_OFF) begin
        forced_q <= 1'b0;
      end
    end
  end

  // Mask is cleared with forcing so nothing carries into the next session
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mask_q <= '0;
    end else if (CLK_EN) begin
      if (wr_mask) begin
        mask_q <= REG_WDATA[5:0];
      end else if (wr_spec && REG_WDATA == SF_FORCE_OFF) begin
        mask_q <= '0;
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DO_OUT <= '0;
    end else if (CLK_EN) begin
      DO_OUT <= forced_q ? mask_q : DO_NORMAL;
    end
  end

  // Two-second shift hold, fires once per press
  assign sign_fire = jog_edit && KEY_SHIFT && !hold_done_q
                     && (hold_cnt_q == 32'(HOLD_CYC - 1));
  assign jog_neg   = 16'(-jog_q);
  assign neg_ok    = ($signed(jog_neg) >= $signed(JOG_MIN))
                     && ($signed(jog_neg) <= $signed(JOG_MAX));

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_cnt_q  <= '0;
      hold_done_q <= 1'b0;
    end else if (CLK_EN) begin
      if (!(jog_edit && KEY_SHIFT)) begin
        hold_cnt_q  <= '0;
        hold_done_q <= 1'b0;
      end else if (sign_fire) begin
        hold_done_q <= 1'b1;
      end else if (!hold_done_q) begin
        hold_cnt_q <= hold_cnt_q + 32'h1;
      end
    end
  end

  // Jog speed: bus write first, then keys, then sign flip
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      jog_q <= JOG_DEFAULT;
    end else if (CLK_EN) begin
      if (wr_jog) begin
        jog_q <= REG_WDATA;
      end else if (jog_edit && up_edge
                   && $signed(jog_q) < $signed(JOG_MAX)) begin
        jog_q <= jog_q + 16'h1;
      end else if (jog_edit && down_edge
                   && $signed(jog_q) > $signed(JOG_MIN)) begin
        jog_q <= jog_q - 16'h1;
      end else if (sign_fire && neg_ok) begin
        jog_q <= jog_neg;
      end
    end
  end

  // Jog drive follows the held key; both keys together means stop
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      JOG_FWD   <= 1'b0;
      JOG_REV   <= 1'b0;
      JOG_SPEED <= '0;
    end else if (CLK_EN) begin
      JOG_FWD   <= (state_q == ST_JOG) && SERVO_ON
                   && KEY_UP && !KEY_DOWN;
      JOG_REV   <= (state_q == ST_JOG) && SERVO_ON
                   && KEY_DOWN && !KEY_UP;
      JOG_SPEED <= jog_q;
    end
  end

  // Monitor page and radix toggles
  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      mon_hex_q  <= 1'b0;
      mon_high_q <= 1'b0;
    end else if (CLK_EN && view_q == VIEW_MON && MON_IS32) begin
      if (set_edge) begin
        mon_hex_q <= !mon_hex_q;
      end
      if (shift_edge) begin
        mon_high_q <= !mon_high_q;
      end
    end
  end

  // Display source; one formatter for all views
  always_comb begin
    req.value = MON_VALUE;
    req.is32  = MON_IS32;
    req.hex   = mon_hex_q && MON_IS32;
    req.high  = mon_high_q && MON_IS32;
    case (view_q)
      VIEW_PARAM: begin
        // Parameters have one fixed 16-bit format each
        req.is32  = 1'b0;
        req.high  = 1'b0;
        req.hex   = 1'b0;
        req.value = {16'h0000, 12'h000, psel_q};
        if (state_q == ST_SHOW && is_fault) begin
          req.value = {16'h0000, FAULT_REC[psel_q[2:0]]};
          req.hex   = 1'b1;
        end else if (state_q == ST_SHOW) begin
          req.value = {{16{jog_q[15]}}, jog_q};
        end else if (psel_q == PSEL_FORCE_MSK) begin
          req.value = {26'h0000000, mask_q};
          req.hex   = 1'b1;
        end else if (psel_q == PSEL_SPEC_FUNC) begin
          req.value = {16'h0000, spec_q};
        end
      end
      VIEW_DI: begin
        req.value = {23'h000000, DI_STATE};
        req.is32  = 1'b0;
        req.hex   = 1'b1;
        req.high  = 1'b0;
      end
      VIEW_DO: begin
        req.value = {26'h0000000, DO_OUT};
        req.is32  = 1'b0;
        req.hex   = 1'b1;
        req.high  = 1'b0;
      end
      default: begin
        req.value = MON_VALUE;
      end
    endcase
  end

  pdd_fmt u_fmt (
    .req  (req),
    .disp (fmt_out)
  );

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      DISP <= '0;
    end else if (CLK_EN) begin
      if (view_q == VIEW_PARAM && state_q == ST_JOG) begin
        DISP.seg <= {GL_BLANK, GL_BLANK, GL_J, GL_O, GL_G};
        DISP.dp  <= '0;
      end else begin
        DISP <= fmt_out;
      end
    end
  end

  // Register read-back, valid only in the cycle after the strobe
  assign status = {8'h00, state_q, mon_high_q, mon_hex_q,
                   JOG_REV, JOG_FWD, forced_q};

  always_comb begin
    case (REG_ADDR)
      ADDR_VIEW:      rd_mux = {14'h0000, view_q};
      ADDR_PARAM_SEL: rd_mux = {12'h000, psel_q};
      ADDR_SPEC_FUNC: rd_mux = spec_q;
      ADDR_FORCE_MSK: rd_mux = {10'h000, mask_q};
      ADDR_JOG_SPEED: rd_mux = jog_q;
      ADDR_STATUS:    rd_mux = status;
      default:        rd_mux = '0;
    endcase
  end

  always_ff @(posedge SYS_CLK or negedge RST_N) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else if (CLK_EN) begin
      REG_RDATA <= REG_RD ? rd_mux : 16'h0000;
    end
  end

endmodule

// [rtl/pdd_pkg.sv]
// Shared constants, types and glyph table for the panel display block
package pdd_pkg;

  // Register word indices on the plain register port
  localparam logic [3:0] ADDR_VIEW      = 4'h0;
  localparam logic [3:0] ADDR_PARAM_SEL = 4'h1;
  localparam logic [3:0] ADDR_SPEC_FUNC = 4'h2;
  localparam logic [3:0] ADDR_FORCE_MSK = 4'h3;
  localparam logic [3:0] ADDR_JOG_SPEED = 4'h4;
  localparam logic [3:0] ADDR_STATUS    = 4'h5;

  // Display views
  localparam logic [1:0] VIEW_MON   = 2'h0;
  localparam logic [1:0] VIEW_PARAM = 2'h1;
  localparam logic [1:0] VIEW_DI    = 2'h2;
  localparam logic [1:0] VIEW_DO    = 2'h3;

  // Parameter indices selectable in parameter view
  localparam logic [3:0] PSEL_FAULT_LAST = 4'h4;
  localparam logic [3:0] PSEL_JOG        = 4'h5;
  localparam logic [3:0] PSEL_FORCE_MSK  = 4'h6;
  localparam logic [3:0] PSEL_SPEC_FUNC  = 4'h8;

  // Special-function codes and defaults
  localparam logic [15:0] SF_FORCE_ON  = 16'h0196;
  localparam logic [15:0] SF_FORCE_OFF = 16'h0190;
  localparam logic [15:0] JOG_DEFAULT  = 16'h0014;
  localparam logic [15:0] JOG_MIN_DEF  = 16'h0000;
  localparam logic [15:0] JOG_MAX_DEF  = 16'h1388;

  // Sign-toggle hold time
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned SIGN_HOLD_MS  = 2000;
  localparam int unsigned SIGN_HOLD_CYC = SIGN_HOLD_MS * (CLK_HZ / 1000);

  // Seven-segment glyphs, bit order g f e d c b a
  localparam logic [6:0] GL_BLANK = 7'h00;
  localparam logic [6:0] GL_HIGH  = 7'h74;
  localparam logic [6:0] GL_LOW   = 7'h38;
  localparam logic [6:0] GL_J     = 7'h1e;
  localparam logic [6:0] GL_O     = 7'h5c;
  localparam logic [6:0] GL_G     = 7'h3d;

  // Panel sequencing states, one-hot
  typedef enum logic [2:0] {
    ST_SEL  = 3'h1,
    ST_SHOW = 3'h2,
    ST_JOG  = 3'h4
  } pdd_state_t;

  typedef struct packed {
    logic [31:0] value;
    logic        is32;
    logic        hex;
    logic        high;
  } pdd_fmt_req_t;

  typedef struct packed {
    logic [4:0][6:0] seg;
    logic [4:0]      dp;
  } pdd_disp_t;

  function automatic logic [6:0] pdd_glyph(input logic [3:0] d);
    logic [6:0] g;
    case (d)
      4'h0: g = 7'h3f;
      4'h1: g = 7'h06;
      4'h2: g = 7'h5b;
      4'h3: g = 7'h4f;
      4'h4: g = 7'h66;
      4'h5: g = 7'h6d;
      4'h6: g = 7'h7d;
      4'h7: g = 7'h07;
      4'h8: g = 7'h7f;
      4'h9: g = 7'h6f;
      4'ha: g = 7'h77;
      4'hb: g = 7'h7c;
      4'hc: g = 7'h39;
      4'hd: g = 7'h5e;
      4'he: g = 7'h79;
      default: g = 7'h71;
    endcase
    return g;
  endfunction

endpackage

// [tb/pdd_operator.sv]
// Keypad operator model: presses one key for a set number of cycles
`timescale 1ns/10ps
module pdd_operator (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       go,
  input  wire logic [2:0] key,
  input  wire logic [7:0] len,
  output logic [4:0]      keys,
  output logic            busy
);
  logic [7:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      keys  <= 5'h00;
      busy  <= 1'b0;
      cnt_q <= 8'h00;
    end else if (go && !busy) begin
      keys  <= 5'h01 << key;
      cnt_q <= len;
      busy  <= 1'b1;
    end else if (cnt_q > 8'h01) begin
      cnt_q <= cnt_q - 8'h01;
    end else if (keys != 5'h00) begin
      // A real finger lets go before the next press, so each is an edge
      keys <= 5'h00;
    end else begin
      busy <= 1'b0;
    end
  end
endmodule

// [tb/pdd_panel_monitor.sv]
// Port-level assertions for the panel block
`timescale 1ns/10ps
module pdd_panel_monitor #(
  parameter logic [15:0] JOG_MIN = pdd_pkg::JOG_MIN_DEF,
  parameter logic [15:0] JOG_MAX = pdd_pkg::JOG_MAX_DEF
) (
  input wire logic               SYS_CLK,
  input wire logic               RST_N,
  input wire logic               CLK_EN,
  input wire logic [3:0]         REG_ADDR,
  input wire logic [15:0]        REG_WDATA,
  input wire logic               REG_WR,
  input wire logic               REG_RD,
  input wire logic [15:0]        REG_RDATA,
  input wire logic               KEY_UP,
  input wire logic               KEY_DOWN,
  input wire logic               SERVO_ON,
  input wire logic [5:0]         DO_NORMAL,
  input wire pdd_pkg::pdd_disp_t DISP,
  input wire logic [5:0]         DO_OUT,
  input wire logic               JOG_FWD,
  input wire logic               JOG_REV,
  input wire logic [15:0]        JOG_SPEED
);
  import pdd_pkg::*;
  default clocking mon_cb @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  rdata_idle_a: assert property ((CLK_EN && !REG_RD) |=> REG_RDATA == 16'h0)
    else $error("read data not zero outside read answer");
  jog_exclusive_a: assert property (!(JOG_FWD && JOG_REV))
    else $error("both jog directions active");
  jog_servo_a: assert property (
    (JOG_FWD || JOG_REV) |-> $past(SERVO_ON))
    else $error("jog motion without servo enabled");
  fwd_rise_a: assert property ($rose(JOG_FWD) |-> $past(KEY_UP))
    else $error("forward jog started without up key");
  fwd_release_a: assert property (
    (!$past(KEY_UP, 2) && !$past(KEY_UP)) |-> !JOG_FWD)
    else $error("forward jog kept after key release");
  rev_release_a: assert property (
    (!$past(KEY_DOWN, 2) && !$past(KEY_DOWN)) |-> !JOG_REV)
    else $error("reverse jog kept after key release");
  force_off_a: assert property (
    (CLK_EN && REG_WR && REG_ADDR == ADDR_SPEC_FUNC
     && REG_WDATA == SF_FORCE_OFF) ##1 1'b1 |=> DO_OUT == $past(DO_NORMAL))
    else $error("outputs still forced after release code");
  sign_points_a: assert property (DISP.dp[4] == DISP.dp[3])
    else $error("sign points differ");
  mid_points_a: assert property (DISP.dp[2:1] == 2'b00)
    else $error("unexpected middle decimal point");
  hex_nosign_a: assert property (
    (DISP.seg[4] == GL_HIGH || DISP.seg[4] == GL_LOW) |-> DISP.dp == 5'h00)
    else $error("hex page shows points");
  speed_range_a: assert property (
    $signed(JOG_SPEED) >= $signed(JOG_MIN)
    && $signed(JOG_SPEED) <= $signed(JOG_MAX))
    else $error("jog speed outside limits");
endmodule

// [tb/testbench.sv]
// Self-checking bench for the panel display block
`timescale 1ns/10ps
module testbench;
  import pdd_pkg::*;
  localparam logic [6:0] SEG_TAB [16] = '{7'h3f, 7'h06, 7'h5b, 7'h4f,
    7'h66, 7'h6d, 7'h7d, 7'h07, 7'h7f, 7'h6f, 7'h77, 7'h7c, 7'h39,
    7'h5e, 7'h79, 7'h71};
  localparam logic [2:0] K_UP = 3'h0;
  localparam logic [2:0] K_DN = 3'h1;
  localparam logic [2:0] K_SET = 3'h2;
  localparam logic [2:0] K_SH = 3'h3;
  localparam logic [2:0] K_MODE = 3'h4;
  logic            SYS_CLK, RST_N, REG_WR, REG_RD, SERVO_ON, MON_IS32;
  logic [3:0]      REG_ADDR;
  logic [15:0]     REG_WDATA, REG_RDATA, JOG_SPEED, d;
  logic [31:0]     MON_VALUE;
  logic [4:0][15:0] FAULT_REC;
  logic [8:0]      DI_STATE;
  logic [5:0]      DO_NORMAL, DO_OUT;
  pdd_disp_t       DISP;
  logic            JOG_FWD, JOG_REV, go, busy, CLK_EN;
  logic [2:0]      key;
  logic [7:0]      len;
  logic [4:0]      keys;
  int              fail_count, samples_checked, cycles;

  pdd_panel #(.HOLD_CYC(8), .JOG_MIN(16'hff9c), .JOG_MAX(16'h1388))
    pdd_panel_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .CLK_EN(CLK_EN),
    .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WR(REG_WR),
    .REG_RD(REG_RD), .REG_RDATA(REG_RDATA), .KEY_UP(keys[0]),
    .KEY_DOWN(keys[1]), .KEY_SET(keys[2]), .KEY_SHIFT(keys[3]),
    .KEY_MODE(keys[4]), .SERVO_ON(SERVO_ON), .MON_VALUE(MON_VALUE),
    .MON_IS32(MON_IS32), .FAULT_REC(FAULT_REC), .DI_STATE(DI_STATE),
    .DO_NORMAL(DO_NORMAL), .DISP(DISP), .DO_OUT(DO_OUT),
    .JOG_FWD(JOG_FWD), .JOG_REV(JOG_REV), .JOG_SPEED(JOG_SPEED));
  pdd_operator pdd_operator_inst (.clk(SYS_CLK), .rst_n(RST_N), .go(go),
    .key(key), .len(len), .keys(keys), .busy(busy));

  initial begin
    SYS_CLK = 1'b0;
    forever #5 SYS_CLK = ~SYS_CLK;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Runaway guard: the whole sequence needs well under a thousand cycles
  always @(posedge SYS_CLK) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  function automatic pdd_disp_t dec(input logic [31:0] v,
                                    input logic [4:0] dp);
    pdd_disp_t r;
    for (int i = 0; i < 5; i++) begin
      r.seg[i] = SEG_TAB[v % 10];
      v = v / 10;
    end
    r.dp = dp;
    return r;
  endfunction

  function automatic pdd_disp_t hx(input logic [15:0] v,
                                   input logic [6:0] lead);
    pdd_disp_t r;
    for (int i = 0; i < 4; i++) r.seg[i] = SEG_TAB[v[i*4+:4]];
    r.seg[4] = lead;
    r.dp = 5'h00;
    return r;
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge SYS_CLK);
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    REG_ADDR <= a;
    REG_WDATA <= v;
    REG_WR <= 1'b1;
    tick(1);
    REG_WR <= 1'b0;
    tick(1);
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] v);
    REG_ADDR <= a;
    REG_RD <= 1'b1;
    tick(1);
    REG_RD <= 1'b0;
    tick(1);
    v = REG_RDATA;
  endtask

  task automatic start(input logic [2:0] k, input logic [7:0] n);
    go <= 1'b1;
    key <= k;
    len <= n;
    tick(1);
    go <= 1'b0;
  endtask

  // Press, release, then allow the two-cycle display lag to pass
  task automatic press(input logic [2:0] k, input logic [7:0] n);
    start(k, n);
    tick(n + 8);
  endtask

  task automatic test_mon();
    MON_VALUE <= 32'd1234;
    tick(3);
    check(DISP, dec(32'd1234, 5'h00));
    MON_VALUE <= 32'hffffcfc7;
    tick(3);
    check(DISP, dec(32'd12345, 5'h18));
    MON_IS32 <= 1'b1;
    MON_VALUE <= 32'd1234567890;
    tick(3);
    check(DISP, dec(32'd67890, 5'h00));
    press(K_SH, 8'd2);
    check(DISP, dec(32'd12345, 5'h01));
    press(K_SET, 8'd2);
    check(DISP, hx(16'h4996, GL_HIGH));
    press(K_SH, 8'd2);
    check(DISP, hx(16'h02d2, GL_LOW));
    MON_VALUE <= 32'hb669fd2e;
    tick(3);
    check(DISP, hx(16'hfd2e, GL_LOW));
    press(K_SET, 8'd2);
    check(DISP, dec(32'd67890, 5'h18));
    $display("monitor test ends");
  endtask

  task automatic test_fault();
    SERVO_ON <= 1'b0;
    wr(ADDR_VIEW, {14'h0, VIEW_PARAM});
    wr(ADDR_PARAM_SEL, 16'h0003);
    tick(3);
    check(DISP, dec(32'd3, 5'h00));
    press(K_SET, 8'd2);
    check(DISP, hx(16'h3c0d, GL_BLANK));
    press(K_SET, 8'd2);
    press(K_UP, 8'd2);
    press(K_SET, 8'd2);
    check(DISP, hx(16'h1234, GL_BLANK));
    press(K_SET, 8'd2);
    $display("fault record test ends");
  endtask

  task automatic test_jog();
    pdd_disp_t j;
    j.seg = {GL_BLANK, GL_BLANK, GL_J, GL_O, GL_G};
    j.dp = 5'h00;
    press(K_UP, 8'd2);
    press(K_SET, 8'd2);
    check(DISP, dec(32'd20, 5'h00));
    check(JOG_SPEED, 16'd20);
    for (int i = 0; i < 3; i++) press(K_UP, 8'd2);
    check(JOG_SPEED, 16'd23);
    press(K_SH, 8'd12);
    check(DISP, dec(32'd23, 5'h18));
    wr(ADDR_JOG_SPEED, 16'd200);
    press(K_SH, 8'd12);
    check(JOG_SPEED, 16'd200);
    press(K_SET, 8'd2);
    check(DISP, j);
    start(K_UP, 8'd10);
    tick(5);
    check(JOG_FWD, 1'b0);
    tick(10);
    SERVO_ON <= 1'b1;
    start(K_UP, 8'd10);
    tick(5);
    check(JOG_FWD, 1'b1);
    rd(ADDR_STATUS, d);
    check(d[2:0], 3'h2);
    tick(8);
    check(JOG_FWD, 1'b0);
    start(K_DN, 8'd10);
    tick(5);
    check({JOG_FWD, JOG_REV}, 2'b01);
    tick(10);
    check(JOG_REV, 1'b0);
    press(K_MODE, 8'd2);
    SERVO_ON <= 1'b0;
    $display("jog test ends");
  endtask

  task automatic test_force();
    wr(ADDR_SPEC_FUNC, SF_FORCE_ON);
    wr(ADDR_FORCE_MSK, 16'h0005);
    tick(3);
    check(DO_OUT, 6'h05);
    check(DISP, hx(16'h0005, GL_BLANK));
    rd(ADDR_VIEW, d);
    check(d, 16'h0003);
    wr(ADDR_SPEC_FUNC, 16'h007b);
    wr(ADDR_FORCE_MSK, 16'h0002);
    tick(3);
    check(DO_OUT, 6'h02);
    wr(ADDR_VIEW, {14'h0, VIEW_PARAM});
    wr(ADDR_PARAM_SEL, {12'h0, PSEL_FORCE_MSK});
    tick(3);
    check(DISP, hx(16'h0002, GL_BLANK));
    wr(ADDR_SPEC_FUNC, SF_FORCE_OFF);
    tick(3);
    check(DO_OUT, 6'h2a);
    rd(ADDR_FORCE_MSK, d);
    check(d, 16'h0000);
    wr(ADDR_SPEC_FUNC, SF_FORCE_ON);
    wr(ADDR_FORCE_MSK, 16'h003f);
    RST_N <= 1'b0;
    tick(2);
    check(DISP, 40'h0);
    RST_N <= 1'b1;
    tick(3);
    check(DO_OUT, 6'h2a);
    $display("forced output test ends");
  endtask

  task automatic test_di();
    DI_STATE <= 9'h1e1;
    wr(ADDR_VIEW, {14'h0, VIEW_DI});
    tick(3);
    check(DISP, hx(16'h01e1, GL_BLANK));
    // Enable low: this write must not land
    CLK_EN <= 1'b0;
    wr(ADDR_VIEW, {14'h0, VIEW_MON});
    CLK_EN <= 1'b1;
    rd(ADDR_VIEW, d);
    check(d, {14'h0, VIEW_DI});
    rd(4'hf, d);
    check(d, 16'h0000);
    $display("input view test ends");
  endtask

  initial begin
    RST_N <= 1'b0;
    REG_WR <= 1'b0;
    REG_RD <= 1'b0;
    REG_ADDR <= 4'h0;
    REG_WDATA <= 16'h0;
    SERVO_ON <= 1'b0;
    MON_IS32 <= 1'b0;
    MON_VALUE <= 32'h0;
    FAULT_REC <= {16'h1234, 16'h3c0d, 16'h2b0a, 16'h1f09, 16'h0e08};
    DI_STATE <= 9'h0;
    DO_NORMAL <= 6'h2a;
    go <= 1'b0;
    key <= 3'h0;
    len <= 8'h0;
    CLK_EN <= 1'b1;
    tick(8);
    RST_N <= 1'b1;
    tick(1);
    test_mon();
    test_fault();
    test_jog();
    test_force();
    test_di();
    give_verdict();
  end
endmodule

bind pdd_panel pdd_panel_monitor #(.JOG_MIN(JOG_MIN), .JOG_MAX(JOG_MAX))
  pdd_panel_monitor_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N),
  .CLK_EN(CLK_EN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA),
  .KEY_UP(KEY_UP), .KEY_DOWN(KEY_DOWN), .SERVO_ON(SERVO_ON),
  .DO_NORMAL(DO_NORMAL), .DISP(DISP), .DO_OUT(DO_OUT),
  .JOG_FWD(JOG_FWD), .JOG_REV(JOG_REV), .JOG_SPEED(JOG_SPEED));
